/* File: src/stack_top_exec.sv */
// Stack top (two arithmetic registers) and word-mode syllable executor.
// Assumes a memory answering a read with rd_valid some cycles later and
// accepting a write when mem_ready is high.
module stack_top_exec (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  input  wire logic [stack_pkg::ADDR_W-1:0] table_base,
  input  wire logic [stack_pkg::ADDR_W-1:0] stack_base,
  input  wire logic                       ptr_load,
  input  wire logic [stack_pkg::ADDR_W-1:0] ptr_init,
  input  wire logic                       syl_valid,
  output logic                            syl_ready,
  input  wire logic [stack_pkg::SYL_W-1:0]  syl,
  input  wire logic signed [stack_pkg::ADDR_W-1:0] rel_offset,
  output logic [stack_pkg::ADDR_W-1:0]    rel_addr,
  output logic                            mem_rd,
  output logic                            mem_wr,
  output logic [stack_pkg::ADDR_W-1:0]    mem_addr,
  output logic [stack_pkg::WORD_W-1:0]    mem_wdata,
  input  wire logic                       mem_ready,
  input  wire logic                       mem_rd_valid,
  input  wire logic [stack_pkg::WORD_W-1:0] mem_rdata,
  output logic [stack_pkg::WORD_W-1:0]    top_a,
  output logic [stack_pkg::WORD_W-1:0]    second_b,
  output logic                            a_valid,
  output logic                            b_valid,
  output logic [stack_pkg::ADDR_W-1:0]    core_ptr,
  output logic                            busy
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  stack_pkg::state_t              state_q;
  stack_pkg::state_t              state_d;
  logic [stack_pkg::WORD_W-1:0]   a_q;
  logic [stack_pkg::WORD_W-1:0]   b_q;
  logic                           av_q;
  logic                           bv_q;
  logic [stack_pkg::ADDR_W-1:0]   s_q;
  logic [stack_pkg::SYL_W-1:0]    syl_q;
  logic [stack_pkg::WORD_W-1:0]   push_q;
  logic                           push_pend_q;
  logic [1:0]                     need_q;
  logic                           rd_out_q;
  logic                           wr_out_q;
  logic [stack_pkg::ADDR_W-1:0]   addr_out_q;
  logic [stack_pkg::WORD_W-1:0]   wdata_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [1:0] need_regs(input logic [stack_pkg::SYL_W-1:0] s);
    logic [1:0] n;
    n = 2'h0;
    if (s[stack_pkg::SYL_TYPE_HI:stack_pkg::SYL_TYPE_LO] == stack_pkg::TYPE_OPER)
    begin
      n = 2'h2;
    end
    return n;
  endfunction : need_regs

  wire [1:0]  syl_type = syl_q[stack_pkg::SYL_TYPE_HI:stack_pkg::SYL_TYPE_LO];
  wire [stack_pkg::IDX_W-1:0] syl_idx = syl_q[stack_pkg::IDX_W-1:0];
  wire [stack_pkg::ADDR_W-1:0] tbl_addr =
    table_base + {{(stack_pkg::ADDR_W-stack_pkg::IDX_W){1'b0}}, syl_idx};
  wire [stack_pkg::WORD_W-1:0] lit_word =
    {{(stack_pkg::WORD_W-stack_pkg::IDX_W){1'b0}}, syl_idx};
  wire [stack_pkg::WORD_W-1:0] address_push_syllable_word =
    {{(stack_pkg::WORD_W-stack_pkg::ADDR_W){1'b0}}, tbl_addr};
  wire [stack_pkg::ADDR_W-1:0] s_inc = s_q + 15'h0001;
  wire [stack_pkg::ADDR_W-1:0] s_dec = s_q - 15'h0001;
  wire [stack_pkg::WORD_W-1:0] sum_ab = a_q + b_q;
  wire [1:0] valid_cnt = {1'b0, av_q} + {1'b0, bv_q};
  wire [stack_pkg::ADDR_W-1:0] address_push_syllable_addr = a_q[stack_pkg::ADDR_W-1:0];
  wire idle = (state_q == stack_pkg::ST_IDLE);
  wire mem_busy = (rd_out_q || wr_out_q) && !mem_ready;

  assign rel_addr  = stack_base + rel_offset;
  assign syl_ready = idle && !push_pend_q;
  assign busy      = !syl_ready;
  assign mem_rd    = rd_out_q;
  assign mem_wr    = wr_out_q;
  assign mem_addr  = addr_out_q;
  assign mem_wdata = wdata_out_q;
  assign top_a     = a_q;
  assign second_b  = b_q;
  assign a_valid   = av_q;
  assign b_valid   = bv_q;
  assign core_ptr  = s_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      stack_pkg::ST_IDLE:
      begin
        if (push_pend_q)
        begin
          state_d = (av_q && bv_q) ? stack_pkg::ST_SPILL : stack_pkg::ST_EXEC;
        end
        else if (syl_valid)
        begin
          state_d = stack_pkg::ST_EXEC;
        end
      end
      stack_pkg::ST_SPILL:     state_d = stack_pkg::ST_EXEC;
      stack_pkg::ST_FILL_RD:   state_d = stack_pkg::ST_FILL_WT;
      stack_pkg::ST_FILL_WT:
      begin
        if (mem_rd_valid)
        begin
          state_d = stack_pkg::ST_EXEC;
        end
      end
      stack_pkg::ST_FETCH_RD:  state_d = stack_pkg::ST_FETCH_WT;
      stack_pkg::ST_FETCH_WT:
      begin
        if (mem_rd_valid)
        begin
          state_d = stack_pkg::ST_IDLE;
        end
      end
      stack_pkg::ST_EXEC:
      begin
        if (mem_busy)
        begin
          state_d = stack_pkg::ST_EXEC;
        end
        else if (push_pend_q)
        begin
          state_d = (av_q && bv_q) ? stack_pkg::ST_SPILL : stack_pkg::ST_IDLE;
        end
        else if (syl_type == stack_pkg::TYPE_OPFET)
        begin
          state_d = stack_pkg::ST_FETCH_RD;
        end
        else if ({1'b0, valid_cnt} < {1'b0, need_q})
        begin
          state_d = stack_pkg::ST_FILL_RD;
        end
        else if (syl_type == stack_pkg::TYPE_OPER && syl_idx == stack_pkg::OP_STORE)
        begin
          state_d = stack_pkg::ST_STORE;
        end
        else
        begin
          state_d = stack_pkg::ST_IDLE;
        end
      end
      stack_pkg::ST_STORE:
      begin
        if (!mem_busy)
        begin
          state_d = stack_pkg::ST_IDLE;
        end
      end
      default:                 state_d = stack_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q <= stack_pkg::ST_IDLE;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      a_q <= '0; b_q <= '0; av_q <= 1'b0; bv_q <= 1'b0;
      s_q <= stack_pkg::PTR_RESET; syl_q <= '0; push_q <= '0;
      push_pend_q <= 1'b0; need_q <= 2'h0;
      rd_out_q <= 1'b0; wr_out_q <= 1'b0;
      addr_out_q <= '0; wdata_out_q <= '0;
    end
    else if (clk_en)
    begin
      if (mem_ready)
      begin
        rd_out_q <= 1'b0;
        wr_out_q <= 1'b0;
      end
      if (ptr_load && idle)
      begin
        s_q <= ptr_init;
      end
      case (state_q)
        stack_pkg::ST_IDLE:
        begin
          if (!push_pend_q && syl_valid)
          begin
            syl_q  <= syl;
            need_q <= need_regs(syl);
            case (syl[stack_pkg::SYL_TYPE_HI:stack_pkg::SYL_TYPE_LO])
              stack_pkg::TYPE_LIT:  push_pend_q <= 1'b1;
              stack_pkg::TYPE_ADDR: push_pend_q <= 1'b1;
              default:              push_pend_q <= 1'b0;
            endcase
          end
        end
        stack_pkg::ST_SPILL:
        begin
          s_q         <= s_inc;
          addr_out_q  <= s_inc;
          wdata_out_q <= b_q;
          wr_out_q    <= 1'b1;
          bv_q        <= 1'b0;
        end
        stack_pkg::ST_FILL_RD:
        begin
          addr_out_q <= s_q;
          rd_out_q   <= 1'b1;
        end
        stack_pkg::ST_FILL_WT:
        begin
          if (mem_rd_valid)
          begin
            // Fill B; a valid B moves up to A first
            if (bv_q)
            begin
              a_q  <= b_q;
              av_q <= 1'b1;
            end
            b_q  <= mem_rdata;
            bv_q <= 1'b1;
            s_q  <= s_dec;
          end
        end
        stack_pkg::ST_FETCH_RD:
        begin
          addr_out_q <= tbl_addr;
          rd_out_q   <= 1'b1;
        end
        stack_pkg::ST_FETCH_WT:
        begin
          if (mem_rd_valid)
          begin
            push_q      <= mem_rdata;
            push_pend_q <= 1'b1;
          end
        end
        stack_pkg::ST_EXEC:
        begin
          if (mem_busy)
          begin
            push_q <= push_q;
          end
          else if (push_pend_q)
          begin
            if (!(av_q && bv_q))
            begin
              // Old top moves down, new word on top
              if (av_q)
              begin
                b_q  <= a_q;
                bv_q <= 1'b1;
              end
              a_q         <= (syl_type == stack_pkg::TYPE_LIT) ? lit_word :
                             (syl_type == stack_pkg::TYPE_ADDR) ? address_push_syllable_word :
                             push_q;
              av_q        <= 1'b1;
              push_pend_q <= 1'b0;
            end
          end
          else if (syl_type == stack_pkg::TYPE_OPER &&
                   {1'b0, valid_cnt} >= {1'b0, need_q})
          begin
            if (syl_idx == stack_pkg::OP_ADD)
            begin
              b_q  <= sum_ab;
              av_q <= 1'b0;
            end
            else if (syl_idx == stack_pkg::OP_XCH)
            begin
              a_q <= b_q;
              b_q <= a_q;
            end
            else if (syl_idx == stack_pkg::OP_STORE)
            begin
              addr_out_q  <= address_push_syllable_addr;
              wdata_out_q <= b_q;
              wr_out_q    <= 1'b1;
            end
          end
        end
        stack_pkg::ST_STORE:
        begin
          if (!mem_busy)
          begin
            av_q <= 1'b0;
            bv_q <= 1'b0;
          end
        end
        default: rd_out_q <= 1'b0;
      endcase
    end
  end

endmodule : stack_top_exec

/* File: src/stack_pkg.sv */
// Package for the word-mode stack top and syllable executor.
// Assumes one clock domain and a single-port word memory on the far side.
package stack_pkg;

  localparam int WORD_W = 48;
  localparam int ADDR_W = 15;
  localparam int SYL_W  = 12;
  localparam int IDX_W  = 10;

  // Syllable type field sits in the two top bits
  localparam int SYL_TYPE_HI = 11;
  localparam int SYL_TYPE_LO = 10;
  localparam logic [1:0] TYPE_OPER  = 2'h0;
  localparam logic [1:0] TYPE_LIT   = 2'h1;
  localparam logic [1:0] TYPE_OPFET = 2'h2;
  localparam logic [1:0] TYPE_ADDR  = 2'h3;

  // Operator codes carried in the low bits of an operator syllable
  localparam logic [IDX_W-1:0] OP_ADD   = 10'h001;
  localparam logic [IDX_W-1:0] OP_XCH   = 10'h002;
  localparam logic [IDX_W-1:0] OP_STORE = 10'h003;

  localparam logic [ADDR_W-1:0] PTR_RESET  = 15'h0000;
  localparam logic [ADDR_W-1:0] BASE_RESET = 15'h0000;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SPILL,
    ST_FILL_RD,
    ST_FILL_WT,
    ST_FETCH_RD,
    ST_FETCH_WT,
    ST_EXEC,
    ST_STORE
  } state_t;

endpackage : stack_pkg

/* File: verif/core_mem_model.sv */
// Core memory model for the stack region and reference table.
// Assumes requests held until mem_ready; wait_n sets the stall length.
module core_mem_model (
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  input  wire logic [3:0]                     wait_n,
  input  wire logic                           mem_rd,
  input  wire logic                           mem_wr,
  input  wire logic [stack_pkg::ADDR_W-1:0]   mem_addr,
  input  wire logic [stack_pkg::WORD_W-1:0]   mem_wdata,
  output logic                                mem_ready,
  output logic                                mem_rd_valid,
  output logic [stack_pkg::WORD_W-1:0]        mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [stack_pkg::WORD_W-1:0] mem [0:32767];
  logic [3:0]                   cnt_q;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mem_ready    <= 1'b0;
      mem_rd_valid <= 1'b0;
      mem_rdata    <= 48'h5a5a_5a5a_5a5a;
      cnt_q        <= 4'h0;
    end
    else
    begin
      mem_rd_valid <= 1'b0;
      // Read data is garbage outside the valid pulse
      mem_rdata    <= ~mem_rdata;
      if (mem_ready)
      begin
        mem_ready <= 1'b0;
        cnt_q     <= 4'h0;
        if (mem_wr)
          mem[mem_addr] <= mem_wdata;
        if (mem_rd)
        begin
          mem_rd_valid <= 1'b1;
          mem_rdata    <= mem[mem_addr];
        end
      end
      else if ((mem_rd || mem_wr) && cnt_q >= wait_n)
        mem_ready <= 1'b1;
      else if (mem_rd || mem_wr)
        cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : core_mem_model

/* File: verif/stack_top_exec_checker.sv */
// Assertions on the stack top and syllable executor ports.
// Bound to every instance of the executor below.
module stack_top_exec_checker (
  input wire logic                               core_clk,
  input wire logic                               sys_rst,
  input wire logic                               clk_en,
  input wire logic [stack_pkg::ADDR_W-1:0]       table_base,
  input wire logic [stack_pkg::ADDR_W-1:0]       stack_base,
  input wire logic                               ptr_load,
  input wire logic                               syl_valid,
  input wire logic                               syl_ready,
  input wire logic [stack_pkg::SYL_W-1:0]        syl,
  input wire logic signed [stack_pkg::ADDR_W-1:0] rel_offset,
  input wire logic [stack_pkg::ADDR_W-1:0]       rel_addr,
  input wire logic                               mem_rd,
  input wire logic                               mem_wr,
  input wire logic [stack_pkg::ADDR_W-1:0]       mem_addr,
  input wire logic [stack_pkg::WORD_W-1:0]       mem_wdata,
  input wire logic                               mem_ready,
  input wire logic                               mem_rd_valid,
  input wire logic [stack_pkg::WORD_W-1:0]       top_a,
  input wire logic [stack_pkg::WORD_W-1:0]       second_b,
  input wire logic                               a_valid,
  input wire logic                               b_valid,
  input wire logic [stack_pkg::ADDR_W-1:0]       core_ptr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0]  val_q;
  logic [14:0] dsc_q;

  // Captures the taken syllable's value and referenced address
  always_ff @(posedge core_clk)
  begin
    if (syl_valid && syl_ready && clk_en)
    begin
      val_q <= syl[9:0];
      dsc_q <= table_base + {5'h00, syl[9:0]};
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence take_s;
    syl_valid && syl_ready && clk_en;
  endsequence
  sequence spill_s;
    mem_wr && !b_valid;
  endsequence

  chk_lit_push: assert property (take_s ##0 (!a_valid &&
    syl[11:10] == stack_pkg::TYPE_LIT) |-> ##[1:2]
    (a_valid && top_a == {38'h0, val_q})) else $error("literal push");
  chk_address_push_syllable_push: assert property (take_s ##0 (!a_valid &&
    syl[11:10] == stack_pkg::TYPE_ADDR) |-> ##[1:2]
    (a_valid && top_a == {33'h0, dsc_q})) else $error("descriptor push");
  chk_spill_addr: assert property (spill_s |->
    mem_addr == core_ptr) else $error("spill address");
  chk_spill_up: assert property ($rose(mem_wr) && !b_valid |->
    core_ptr == $past(core_ptr) + 15'h0001) else $error("spill pointer");
  chk_fill_dec: assert property (!$past(ptr_load) &&
    core_ptr == $past(core_ptr) - 15'h0001 |-> $past(mem_rd_valid))
    else $error("pointer drop without word");
  chk_ptr_step: assert property (!$past(ptr_load) |->
    core_ptr == $past(core_ptr) || core_ptr == $past(core_ptr) + 15'h0001
    || core_ptr == $past(core_ptr) - 15'h0001) else $error("pointer jump");
  chk_store_wr: assert property (mem_wr && a_valid && b_valid |->
    mem_addr == top_a[14:0] && mem_wdata == second_b)
    else $error("store write");
  chk_store_clr: assert property (mem_wr && mem_ready && a_valid
    && b_valid |-> ##[1:2] (!a_valid && !b_valid)) else $error("store clear");
  chk_rel_addr: assert property (rel_addr ==
    stack_base + $unsigned(rel_offset)) else $error("relative address");
  chk_req_hold: assert property ((mem_rd || mem_wr) && !mem_ready |=>
    (mem_rd || mem_wr) && $stable(mem_addr)) else $error("request dropped");
endmodule : stack_top_exec_checker

bind stack_top_exec stack_top_exec_checker u_chk (.*);

/* File: verif/stack_top_exec_bench.sv */
// Self-checking bench for the stack top and syllable executor.
// Core memory model on the far side; inputs driven on falling edges.
module stack_top_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, ptr_load = 0, syl_valid = 0;
  logic [14:0] table_base = 15'h0300, stack_base = 15'h0200;
  logic [14:0] ptr_init = 15'h01ff, rel_addr, mem_addr, core_ptr;
  logic [11:0] syl = 12'h000;
  logic signed [14:0] rel_offset = 15'sh0000;
  logic [47:0] mem_wdata, mem_rdata, top_a, second_b, sum;
  logic syl_ready, mem_rd, mem_wr, mem_ready, mem_rd_valid;
  logic a_valid, b_valid, busy;
  logic [3:0] wait_n = 4'h0;
  int bad_count = 0, n_tests = 0;
  localparam logic [47:0] X = 48'h1234_5678_9abc, Y = 48'h0fed_cba9_8765;
  localparam logic [47:0] DSC = 48'h0000_0000_0364;

  stack_top_exec u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .table_base(table_base), .stack_base(stack_base),
    .ptr_load(ptr_load), .ptr_init(ptr_init), .syl_valid(syl_valid),
    .syl_ready(syl_ready), .syl(syl), .rel_offset(rel_offset),
    .rel_addr(rel_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rd_valid(mem_rd_valid), .mem_rdata(mem_rdata), .top_a(top_a),
    .second_b(second_b), .a_valid(a_valid), .b_valid(b_valid),
    .core_ptr(core_ptr), .busy(busy));
  core_mem_model u_mem (.core_clk(core_clk), .sys_rst(sys_rst),
    .wait_n(wait_n), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rd_valid(mem_rd_valid), .mem_rdata(mem_rdata));

  initial
  begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [47:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Offers one syllable, then waits until the executor is idle again;
  // a hang is left to the watchdog
  task automatic send(input logic [1:0] t, input logic [9:0] v);
    @(negedge core_clk);
    syl = {t, v};
    syl_valid = 1'b1;
    while (syl_ready !== 1'b1)
      @(negedge core_clk);
    @(negedge core_clk);
    syl_valid = 1'b0;
    while (syl_ready !== 1'b1)
      @(negedge core_clk);
  endtask : send

  task automatic t_push();
    u_mem.mem[15'h0320] = X;
    u_mem.mem[15'h032d] = Y;
    send(stack_pkg::TYPE_ADDR, 10'h064);
    chk("descriptor", DSC, top_a);
    send(stack_pkg::TYPE_OPFET, 10'h020);
    chk("fetch top", X, top_a);
    chk("fetch second", DSC, second_b);
    send(stack_pkg::TYPE_OPFET, 10'h02d);
    chk("spill ptr", 48'h200, {33'h0, core_ptr});
    chk("spill word", DSC, u_mem.mem[15'h0200]);
    chk("spill top", Y, top_a);
    wait_n = 4'h3;
    send(stack_pkg::TYPE_LIT, 10'h3ff);
    chk("literal", 48'h0000_0000_03ff, top_a);
    chk("slow spill", X, u_mem.mem[15'h0201]);
  endtask : t_push

  task automatic t_arith();
    send(stack_pkg::TYPE_OPER, stack_pkg::OP_ADD);
    chk("add sum", Y + 48'h3ff, second_b);
    chk("add a empty", 48'h0, {47'h0, a_valid});
    send(stack_pkg::TYPE_OPER, stack_pkg::OP_ADD);
    sum = X + Y + 48'h3ff;
    chk("fill ptr", 48'h200, {33'h0, core_ptr});
    chk("fill sum", sum, second_b);
    wait_n = 4'h0;
    send(stack_pkg::TYPE_OPER, stack_pkg::OP_XCH);
    chk("xch top", DSC, top_a);
    chk("xch second", sum, second_b);
    chk("xch ptr", 48'h1ff, {33'h0, core_ptr});
    send(stack_pkg::TYPE_OPER, stack_pkg::OP_STORE);
    chk("store word", sum, u_mem.mem[15'h0364]);
    chk("store flags", 48'h0, {46'h0, a_valid, b_valid});
  endtask : t_arith

  task automatic t_zero_idx();
    u_mem.mem[15'h0300] = Y;
    send(stack_pkg::TYPE_OPFET, 10'h000);
    chk("index zero", Y, top_a);
    send(stack_pkg::TYPE_LIT, 10'h000);
    send(stack_pkg::TYPE_OPER, stack_pkg::OP_XCH);
    chk("xch both top", Y, top_a);
    chk("xch both second", 48'h0, second_b);
    send(stack_pkg::TYPE_OPER, stack_pkg::OP_ADD);
    send(stack_pkg::TYPE_LIT, 10'h02a);
    chk("lit over b top", 48'h0000_0000_002a, top_a);
    chk("lit over b second", Y, second_b);
  endtask : t_zero_idx

  // Syllable offered while the clock enable is low must not be taken
  task automatic t_freeze();
    @(negedge core_clk);
    clk_en = 1'b0;
    send(stack_pkg::TYPE_LIT, 10'h155);
    chk("frozen top", 48'h0000_0000_002a, top_a);
    clk_en = 1'b1;
  endtask : t_freeze

  task automatic t_rel();
    @(negedge core_clk);
    rel_offset = -15'sd3;
    #1 chk("rel negative", 48'h1fd, {33'h0, rel_addr});
    rel_offset = 15'sd5;
    #1 chk("rel positive", 48'h205, {33'h0, rel_addr});
  endtask : t_rel

  initial
  begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("reset flags", 48'h0, {45'h0, busy, a_valid, b_valid});
    ptr_load = 1'b1;
    @(negedge core_clk);
    ptr_load = 1'b0;
    t_push();
    t_arith();
    t_zero_idx();
    t_freeze();
    t_rel();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    summarize();
  end
endmodule : stack_top_exec_bench
